/* fpu_flags_pkg.sv */
// Package for the floating-point control and status flag block.
// Assumes a 32-bit register port with one-cycle read latency.
package fpu_flags_pkg;
  localparam int unsigned ADDR_W            = 4;
  localparam int unsigned DATA_W            = 32;
  localparam logic [3:0]  ADDR_CTRL_ZERO    = 4'h0;
  localparam logic [3:0]  ADDR_STATUS_WORD  = 4'h1;
  localparam logic [3:0]  ADDR_TASK_FLAGS   = 4'h2;
  localparam int unsigned BIT_MONITOR       = 1;
  localparam int unsigned BIT_COPROC_TYPE   = 4;
  localparam int unsigned BIT_ERR_REPORT    = 5;
  localparam int unsigned BIT_TASK_SWITCHED = 0;
  localparam int unsigned BIT_CC0           = 8;
  localparam int unsigned BIT_CC1           = 9;
  localparam int unsigned BIT_CC2           = 10;
  localparam int unsigned BIT_CC3           = 14;
  localparam logic [31:0] CTRL_ZERO_RESET   = 32'h0000_0010;
  localparam logic [31:0] CTRL_WRITE_MASK   = 32'hFFFF_FFEF;
  localparam logic [3:0]  CC_RESET          = 4'h0;
  localparam logic [7:0]  VEC_NUMERIC_ERR   = 8'h10;
  localparam logic [7:0]  VEC_DEV_NOT_AVAIL = 8'h07;
  typedef enum logic [2:0] {
    FAULT_NONE   = 3'b001,
    FAULT_DEVNA  = 3'b010,
    FAULT_NUMERR = 3'b100
  } fault_t;
endpackage

/* fpu_control_status_flags.sv */
// Control register zero flags and floating-point condition codes.
// Assumes the integer unit presents one-cycle op pulses synchronous to sys_clk.
// Functional notes
// - The coprocessor type flag at bit 4 of control register zero always reads as 1.
// - With the error report flag at bit 5 set, unmasked errors not preempted by a same-cycle device-not-available go internally on vector 16, else externally.
// - Hardware reset clears the error report flag; software sets it to use internal reporting.
// - With monitor flag bit 1 and task switched set, waiting instructions raise device-not-available on vector 7.
// - Condition code bits 0..3 sit at status word bits 8, 9, 10 and 14.
// - Initialize and hardware reset clear all four condition code bits.
// - An incomplete partial remainder, either variant, clears condition code bits 0, 1 and 3.
// - Condition code bit 2 flags an incomplete partial tangent.
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/100ps
`default_nettype none
module fpu_control_status_flags
  import fpu_flags_pkg::*;
(
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rst_b,
  // Register port
  input  wire logic [fpu_flags_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [fpu_flags_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [fpu_flags_pkg::DATA_W-1:0] reg_rdata,
  // Floating-point operation events
  input  wire logic                        fpu_initialize_op,
  input  wire logic                        partial_remainder_op,
  input  wire logic                        ieee_partial_remainder_op,
  input  wire logic                        partial_tangent_op,
  input  wire logic                        op_incomplete,
  input  wire logic                        cc_load,
  input  wire logic [3:0]                  cc_load_value,
  input  wire logic                        wait_for_fpu_op,
  input  wire logic                        unmasked_fp_error,
  // Fault outputs
  output logic                             fault_valid,
  output logic      [7:0]                  fault_vector,
  output logic                             ext_fp_error
);
  import fpu_flags_pkg::*;

  logic       rst_meta;
  logic       rst_sync_b;
  logic [31:0] ctrl_zero;
  logic [31:0] next_ctrl_zero;
  logic        task_switched_flag;
  logic        next_task_switched_flag;
  logic [3:0]  cc;
  logic [3:0]  next_cc;
  logic [31:0] next_rdata;
  fault_t      fault;
  fault_t      next_fault;
  logic        next_ext_err;

  function automatic logic [15:0] status_word(input logic [3:0] c);
    logic [15:0] s;
    s = 16'h0000;
    s[BIT_CC0] = c[0];
    s[BIT_CC1] = c[1];
    s[BIT_CC2] = c[2];
    s[BIT_CC3] = c[3];
    return s;
  endfunction

  // Reset release through two flops
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta   <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_b <= rst_meta;
    end
  end

  wire logic remainder_any = partial_remainder_op | ieee_partial_remainder_op;
  wire logic monitor_flag  = ctrl_zero[BIT_MONITOR];
  wire logic error_report  = ctrl_zero[BIT_ERR_REPORT];

  // Register writes
  always_comb begin
    next_ctrl_zero          = ctrl_zero;
    next_task_switched_flag = task_switched_flag;
    if (reg_wr && reg_addr == ADDR_CTRL_ZERO) begin
      next_ctrl_zero = reg_wdata & CTRL_WRITE_MASK;
    end else if (reg_wr && reg_addr == ADDR_TASK_FLAGS) begin
      next_task_switched_flag = reg_wdata[BIT_TASK_SWITCHED];
    end
    next_ctrl_zero[BIT_COPROC_TYPE] = 1'b1;
  end

  // Condition codes; initialize wins over any other update
  always_comb begin
    next_cc = cc;
    if (fpu_initialize_op) begin
      next_cc = CC_RESET;
    end else if (remainder_any && op_incomplete) begin
      next_cc    = CC_RESET;
      next_cc[2] = 1'b1;
    end else if (partial_tangent_op) begin
      next_cc    = cc;
      next_cc[2] = op_incomplete;
    end else if (cc_load) begin
      next_cc = cc_load_value;
    end
  end

  // Fault routing: device-not-available outranks numeric error
  always_comb begin
    next_fault   = FAULT_NONE;
    next_ext_err = 1'b0;
    if (wait_for_fpu_op && monitor_flag && task_switched_flag) begin
      next_fault = FAULT_DEVNA;
    end else if (unmasked_fp_error && error_report) begin
      next_fault = FAULT_NUMERR;
    end else if (unmasked_fp_error) begin
      next_ext_err = 1'b1;
    end
  end

  // Read data, valid the cycle after the strobe only
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_rd) begin
      if (reg_addr == ADDR_CTRL_ZERO) begin
        next_rdata = ctrl_zero;
      end else if (reg_addr == ADDR_STATUS_WORD) begin
        next_rdata = {16'h0000, status_word(cc)};
      end else if (reg_addr == ADDR_TASK_FLAGS) begin
        next_rdata = {31'h0000_0000, task_switched_flag};
      end else begin
        next_rdata = 32'h0000_0000;
      end
    end
  end

  // Control state; internal error reporting stays off until software turns it on
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ctrl_zero          <= CTRL_ZERO_RESET;
      task_switched_flag <= 1'b0;
    end else begin
      ctrl_zero          <= next_ctrl_zero;
      task_switched_flag <= next_task_switched_flag;
    end
  end

  chk_type_flag_one: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_b)
    ctrl_zero[BIT_COPROC_TYPE] == 1'b1
  ) else $error("type flag not 1");

  chk_reset_err_flag: assert property (
    @(posedge sys_clk)
    $rose(rst_sync_b) |-> !error_report
  ) else $error("error flag set after reset");

  chk_ctrl_hold: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_b)
    !(reg_wr && reg_addr == ADDR_CTRL_ZERO) |=> $stable(ctrl_zero)
  ) else $error("control register changed without a write");

  chk_type_write_ignored: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_b)
    (reg_wr && reg_addr == ADDR_CTRL_ZERO) |=> (ctrl_zero[5] == $past(reg_wdata[5]) && ctrl_zero[4])
  ) else $error("control write wrong");

  chk_ctrl_other_bits: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_b)
    (reg_wr && reg_addr == ADDR_CTRL_ZERO) |=>
      (ctrl_zero[31:5] == $past(reg_wdata[31:5]) && ctrl_zero[3:0] == $past(reg_wdata[3:0]))
  ) else $error("control bits beside the type flag lost");

  chk_task_flag_write: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_b)
    (reg_wr && reg_addr == ADDR_TASK_FLAGS) |=> task_switched_flag == $past(reg_wdata[0])
  ) else $error("task switched flag write lost");

  // Condition codes
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cc <= CC_RESET;
    end else begin
      cc <= next_cc;
    end
  end

  chk_cc_reset_zero: assert property (
    @(posedge sys_clk)
    $rose(rst_sync_b) |-> cc == 4'h0
  ) else $error("codes not clear after reset");

  chk_init_clears: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_b)
    fpu_initialize_op |=> cc == 4'h0
  ) else $error("init did not clear codes");

  chk_rem_clears: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_b)
    (!fpu_initialize_op && remainder_any && op_incomplete) |=>
      (cc[0] == 1'b0 && cc[1] == 1'b0 && cc[3] == 1'b0)
  ) else $error("remainder did not clear codes");

  chk_rem_sets_cc2: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_b)
    (!fpu_initialize_op && remainder_any && op_incomplete) |=> cc[2] == 1'b1
  ) else $error("remainder did not flag incomplete");

  chk_tan_incomplete: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_b)
    (!fpu_initialize_op && !remainder_any && partial_tangent_op) |=> cc[2] == $past(op_incomplete)
  ) else $error("tangent incomplete wrong");

  chk_tan_keeps_codes: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_b)
    (!fpu_initialize_op && !remainder_any && partial_tangent_op) |=>
      (cc[0] == $past(cc[0]) && cc[1] == $past(cc[1]) && cc[3] == $past(cc[3]))
  ) else $error("tangent disturbed other codes");

  chk_cc_quiet: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_b)
    !(fpu_initialize_op || remainder_any || partial_tangent_op || cc_load) |=> $stable(cc)
  ) else $error("codes changed with no op");

  // Fault pulses last one cycle; the integer unit must take them on the next edge
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      fault        <= FAULT_NONE;
      ext_fp_error <= 1'b0;
    end else begin
      fault        <= next_fault;
      ext_fp_error <= next_ext_err;
    end
  end

  always_comb begin
    fault_valid  = 1'b0;
    fault_vector = 8'h00;
    case (fault)
      FAULT_DEVNA: begin
        fault_valid  = 1'b1;
        fault_vector = VEC_DEV_NOT_AVAIL;
      end
      FAULT_NUMERR: begin
        fault_valid  = 1'b1;
        fault_vector = VEC_NUMERIC_ERR;
      end
      default: begin
        fault_valid  = 1'b0;
        fault_vector = 8'h00;
      end
    endcase
  end

  chk_numerr_internal: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_b)
    (unmasked_fp_error && !wait_for_fpu_op && error_report) |=>
      (fault_valid && fault_vector == 8'h10 && !ext_fp_error)
  ) else $error("internal error report wrong");

  chk_numerr_external: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_b)
    (unmasked_fp_error && !wait_for_fpu_op && !error_report) |=>
      (ext_fp_error && !fault_valid)
  ) else $error("external error report wrong");

  chk_devna_vector: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_b)
    (wait_for_fpu_op && monitor_flag && task_switched_flag) |=>
      (fault_valid && fault_vector == 8'h07)
  ) else $error("device not available missing");

  chk_no_fault_idle: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_b)
    (!unmasked_fp_error && !(wait_for_fpu_op && monitor_flag && task_switched_flag)) |=>
      (!fault_valid && !ext_fp_error)
  ) else $error("fault raised with no cause");

  // Read data stand for one cycle only, so a late sample reads zero
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  chk_status_layout: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_b)
    (reg_rd && reg_addr == ADDR_STATUS_WORD) |=>
      (reg_rdata[14] == $past(cc[3]) && reg_rdata[10] == $past(cc[2]) &&
       reg_rdata[9] == $past(cc[1]) && reg_rdata[8] == $past(cc[0]))
  ) else $error("status layout wrong");

  chk_status_spare_zero: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_b)
    (reg_rd && reg_addr == ADDR_STATUS_WORD) |=>
      (reg_rdata[31:15] == 17'h0_0000 && reg_rdata[13:11] == 3'h0 && reg_rdata[7:0] == 8'h00)
  ) else $error("status spare bits not zero");

  chk_ctrl_readback: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_b)
    (reg_rd && reg_addr == ADDR_CTRL_ZERO) |=> reg_rdata[4] == 1'b1
  ) else $error("type flag read back wrong");

  chk_rdata_idle: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_b)
    !reg_rd |=> reg_rdata == 32'h0000_0000
  ) else $error("read data outside read cycle");
endmodule
`default_nettype wire

/* fpu_int_unit_model.sv */
// Behavioural integer unit that issues floating-point op events.
// Assumes the bench calls issue() from one thread, clocked by sys_clk.
`timescale 1ns/100ps
`default_nettype none
module fpu_int_unit_model (
  // Clock
  input  wire logic       sys_clk,
  // Op events
  output var  logic       init_op,
  output var  logic       rem_op,
  output var  logic       ieee_rem_op,
  output var  logic       tan_op,
  output var  logic       incomplete,
  output var  logic       load_op,
  output var  logic [3:0] load_val,
  output var  logic       wait_op,
  output var  logic       fp_error
);
  initial begin
    {init_op, rem_op, ieee_rem_op, tan_op, incomplete, load_op, load_val, wait_op, fp_error} = '0;
  end
  // Kind 0 init, 1 rem, 2 ieee rem, 3 tan, 4 load, 5 wait, 6 error; one-cycle pulse
  task automatic issue(input int kind, input logic inc, input logic [3:0] val);
    @(posedge sys_clk);
    incomplete <= inc;
    load_val <= val;
    case (kind)
      0: init_op <= 1'b1;
      1: rem_op <= 1'b1;
      2: ieee_rem_op <= 1'b1;
      3: tan_op <= 1'b1;
      4: load_op <= 1'b1;
      5: wait_op <= 1'b1;
      default: fp_error <= 1'b1;
    endcase
    @(posedge sys_clk);
    // Qualifiers dropped too, so a stale level is never mistaken for a new op
    {init_op, rem_op, ieee_rem_op, tan_op, incomplete, load_op, load_val, wait_op, fp_error} <= '0;
  endtask
endmodule
`default_nettype wire

/* fpu_control_status_flags_bench.sv */
// Self-checking bench for the control and status flag block.
// Assumes the model drives op events; the bench owns the register port.
`timescale 1ns/100ps
`default_nettype none
module fpu_control_status_flags_bench;
  import fpu_flags_pkg::*;
  logic              sys_clk, rst_b, reg_wr, reg_rd, fin, rem, irem, tan, inc, ld, wt, uerr;
  logic              fault_valid, ext_fp_error;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic [3:0]        ccv;
  logic [7:0]        fault_vector;
  int                err_count = 0, checks_done = 0, cycles = 0;
  fpu_control_status_flags i_fpu_control_status_flags (.sys_clk(sys_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fpu_initialize_op(fin), .partial_remainder_op(rem), .ieee_partial_remainder_op(irem),
    .partial_tangent_op(tan), .op_incomplete(inc), .cc_load(ld), .cc_load_value(ccv),
    .wait_for_fpu_op(wt), .unmasked_fp_error(uerr), .fault_valid(fault_valid),
    .fault_vector(fault_vector), .ext_fp_error(ext_fp_error));
  fpu_int_unit_model i_fpu_int_unit_model (.sys_clk(sys_clk), .init_op(fin), .rem_op(rem),
    .ieee_rem_op(irem), .tan_op(tan), .incomplete(inc), .load_op(ld), .load_val(ccv),
    .wait_op(wt), .fp_error(uerr));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic give_verdict;
    if (err_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Ceiling far above the roughly 81 cycles the sequence needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      give_verdict;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask
  // Fault outputs packed as {valid, vector, external}, seen in the cycle after the op
  task automatic op(input int k, input logic i, input logic [3:0] v, input logic [31:0] exp);
    i_fpu_int_unit_model.issue(k, i, v);
    #1 check({22'h0, fault_valid, fault_vector, ext_fp_error}, exp);
  endtask
  task automatic do_reset(input int n);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (n) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask
  initial begin
    rst_b <= 1'b0;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    do_reset(5);
    rd(ADDR_CTRL_ZERO, 32'h0000_0010);
    rd(ADDR_STATUS_WORD, 32'h0000_0000);
    rd(4'hF, 32'h0000_0000);
    wr(ADDR_CTRL_ZERO, 32'h0000_0000);
    rd(ADDR_CTRL_ZERO, 32'h0000_0010);
    wr(ADDR_CTRL_ZERO, 32'h0000_0022);
    rd(ADDR_CTRL_ZERO, 32'h0000_0032);
    op(5, 1'b0, 4'h0, 32'h0000_0000);
    wr(ADDR_TASK_FLAGS, 32'h0000_0001);
    op(5, 1'b0, 4'h0, 32'h0000_020E);
    op(6, 1'b0, 4'h0, 32'h0000_0220);
    wr(ADDR_CTRL_ZERO, 32'h0000_0002);
    op(6, 1'b0, 4'h0, 32'h0000_0001);
    wr(ADDR_CTRL_ZERO, 32'h0000_0000);
    op(5, 1'b0, 4'h0, 32'h0000_0000);
    op(4, 1'b0, 4'hF, 32'h0000_0000);
    rd(ADDR_STATUS_WORD, 32'h0000_4700);
    op(1, 1'b1, 4'h0, 32'h0000_0000);
    rd(ADDR_STATUS_WORD, 32'h0000_0400);
    op(4, 1'b0, 4'hF, 32'h0000_0000);
    op(2, 1'b1, 4'h0, 32'h0000_0000);
    rd(ADDR_STATUS_WORD, 32'h0000_0400);
    op(4, 1'b0, 4'hB, 32'h0000_0000);
    op(3, 1'b1, 4'h0, 32'h0000_0000);
    rd(ADDR_STATUS_WORD, 32'h0000_4700);
    op(3, 1'b0, 4'h0, 32'h0000_0000);
    rd(ADDR_STATUS_WORD, 32'h0000_4300);
    op(0, 1'b0, 4'h0, 32'h0000_0000);
    rd(ADDR_STATUS_WORD, 32'h0000_0000);
    wr(ADDR_CTRL_ZERO, 32'h0000_0022);
    op(4, 1'b0, 4'hF, 32'h0000_0000);
    do_reset(2);
    rd(ADDR_STATUS_WORD, 32'h0000_0000);
    rd(ADDR_CTRL_ZERO, 32'h0000_0010);
    give_verdict;
  end
endmodule
`default_nettype wire
